// ---- design/sprom_pkg.sv ----
// constants and carrier types for the static memory and boot rom interface
package sprom_pkg;
  localparam int SPROM_CLK_HZ = 40000000;
  localparam int SPROM_NBANK = 3;
  // register word addresses (avalon word addressing)
  localparam logic [3:0] SPROM_REG_BANK0 = 4'h0;
  localparam logic [3:0] SPROM_REG_BANK1 = 4'h1;
  localparam logic [3:0] SPROM_REG_BANK2 = 4'h2;
  localparam logic [3:0] SPROM_REG_REFRESH = 4'h3;
  localparam logic [3:0] SPROM_REG_STANDBY = 4'h4;
  localparam logic [3:0] SPROM_REG_STATUS = 4'h5;
  // bank register fields
  localparam int SPROM_F_TYPE = 0;
  localparam int SPROM_F_WIDE = 2;
  localparam int SPROM_F_ROMSEL = 3;
  localparam int SPROM_F_POL = 4;
  localparam int SPROM_F_WAIT = 8;
  localparam logic [31:0] SPROM_ENABLE_BIT = 32'h0000_0001;
  // bank 0 resets to xt bus, byte wide, rom select on, active low
  localparam logic [7:0] SPROM_BANK0_RST = 8'h0A;
  localparam logic [7:0] SPROM_BANKN_RST = 8'h01;
  localparam logic [3:0] SPROM_WAIT_RST = 4'h3;
  // timing
  localparam int SPROM_SUSP_PULSE_NS = 8000;
  localparam int SPROM_SUSP_PULSE_CYC = (SPROM_SUSP_PULSE_NS * (SPROM_CLK_HZ / 1000000)
                                         + 999) / 1000;
  localparam int SPROM_RFSH_PULSE_NS = 100;
  localparam int SPROM_RFSH_PULSE_CYC = (SPROM_RFSH_PULSE_NS * (SPROM_CLK_HZ / 1000000)
                                         + 999) / 1000;
  localparam int SPROM_XT_EXTRA = 4;
  typedef enum logic [1:0] {
    SPROM_CYC_DRAM,
    SPROM_CYC_SRAM,
    SPROM_CYC_XT,
    SPROM_CYC_CARD
  } sprom_cyc_type;
  typedef struct packed {
    logic [3:0] wait_cnt;
    logic pol_high;
    logic rom_sel;
    logic wide;
    sprom_cyc_type cyc;
  } sprom_bank_type;
  typedef enum logic [2:0] {
    SPROM_IDLE,
    SPROM_ACCESS,
    SPROM_DONE,
    SPROM_SUSP_PULSE,
    SPROM_SUSPEND
  } sprom_state_type;
  typedef struct packed {
    logic [19:0] addr;
    logic [15:0] wdata;
    logic [1:0] lanes;
    logic write;
  } sprom_req_type;
  typedef struct packed {
    logic [18:0] sram_addr;
    logic [2:0] bank_sel;
    logic [1:0] oe_n;
    logic [1:0] we_n;
    logic [15:0] data_out;
    logic data_oe;
    logic refresh_n;
  } sprom_sram_pins_type;
  typedef struct packed {
    logic [19:0] rom_addr;
    logic boot_rom_select_n;
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
  } sprom_rom_pins_type;
endpackage

// ---- design/sprom_ctrl.sv ----
// static memory, pseudo static refresh and boot rom controller
//
// Added by the designer: the register addresses and the Avalon-MM register port.
`timescale 1ns/100ps
module sprom_ctrl
  import sprom_pkg::*;
#(
  parameter int RFSH_PERIOD = 600,
  parameter int SUSP_PULSE_CYC = SPROM_SUSP_PULSE_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm register slave
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // memory request from the cpu side, same clock
  input wire logic mem_req_i,
  input wire logic [1:0] mem_bank_i,
  input wire sprom_req_type mem_cmd_i,
  output logic mem_ack_o,
  output logic [15:0] mem_rdata_o,
  // power management, same clock
  input wire logic suspend_req_i,
  output logic suspended_o,
  // sram / psram pins
  input wire logic [15:0] ram_data_i,
  output sprom_sram_pins_type sram_o,
  // rom on the xt bus
  input wire logic [7:0] rom_data_i,
  output sprom_rom_pins_type rom_o
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    sprom_bank_type [SPROM_NBANK-1:0] bank;
    logic rfsh_en;
    logic standby_mode;
    sprom_state_type st;
    logic [1:0] cur_bank;
    sprom_req_type req;
    logic hi_phase;
    logic [15:0] rdata;
    logic [15:0] tmr;
    logic [15:0] rfsh_cnt;
    logic [7:0] rfsh_width;
    logic rfsh_due;
    logic busy;
    logic ack;
    logic [31:0] rd;
    logic wait_n;
    logic waitreq;
    logic susp;
    sprom_sram_pins_type sram;
    sprom_rom_pins_type rom;
  } sprom_all_type;

  sprom_all_type s_q;
  sprom_all_type s_d;
  sprom_bank_type cb;
  logic rfsh_active;
  logic xt_cycle;
  logic acc_ok;
  logic rfsh_wrap;

  // currently addressed bank decoded once for the access state machine; the pin groups decode the next-state bank themselves
  assign cb = s_q.bank[s_q.cur_bank];
  assign xt_cycle = (cb.cyc == SPROM_CYC_XT);
  assign rfsh_active = (s_q.rfsh_width != 8'h00);
  // card and dram cycles belong to other blocks and are acked at once
  assign acc_ok = (cb.cyc == SPROM_CYC_SRAM) || xt_cycle;
  assign rfsh_wrap = (s_q.rfsh_cnt >= 16'(RFSH_PERIOD - 1));

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.wait_n = 1'b0;
    // avalon slave: one wait cycle, answer on the second edge
    if ((avs_read_i || avs_write_i) && !s_q.wait_n) begin
      s_d.wait_n = 1'b1;
      s_d.rd = 32'h0000_0000;
      if (avs_address_i == SPROM_REG_BANK0) begin
        s_d.rd[11:0] = {s_q.bank[0].wait_cnt, 3'h0, s_q.bank[0][4:0]};
      end else if (avs_address_i == SPROM_REG_BANK1) begin
        s_d.rd[11:0] = {s_q.bank[1].wait_cnt, 3'h0, s_q.bank[1][4:0]};
      end else if (avs_address_i == SPROM_REG_BANK2) begin
        s_d.rd[11:0] = {s_q.bank[2].wait_cnt, 3'h0, s_q.bank[2][4:0]};
      end else if (avs_address_i == SPROM_REG_REFRESH) begin
        s_d.rd[0] = s_q.rfsh_en;
      end else if (avs_address_i == SPROM_REG_STANDBY) begin
        s_d.rd[0] = s_q.standby_mode;
      end else if (avs_address_i == SPROM_REG_STATUS) begin
        s_d.rd[2:0] = {s_q.st == SPROM_SUSPEND, s_q.st == SPROM_SUSP_PULSE, s_q.busy};
      end
    end
    // a write lands only at the edge where the master sees waitrequest low
    if (avs_write_i && s_q.wait_n) begin
      if (avs_address_i <= SPROM_REG_BANK2) begin
        // configuration sets cycle type, width, rom select, polarity per bank
        s_d.bank[avs_address_i[1:0]] = {avs_writedata_i[SPROM_F_WAIT +: 4],
                                        avs_writedata_i[SPROM_F_POL],
                                        avs_writedata_i[SPROM_F_ROMSEL],
                                        avs_writedata_i[SPROM_F_WIDE],
                                        sprom_cyc_type'(avs_writedata_i[SPROM_F_TYPE +: 2])
                                       };
      end else if (avs_address_i == SPROM_REG_REFRESH) begin
        s_d.rfsh_en = avs_writedata_i[0];
      end else if (avs_address_i == SPROM_REG_STANDBY) begin
        s_d.standby_mode = avs_writedata_i[0];
      end
    end
    s_d.waitreq = !s_d.wait_n;

    // periodic refresh timer; a due refresh waits for the pins to be free
    if (rfsh_wrap) begin
      s_d.rfsh_cnt = 16'h0000;
      s_d.rfsh_due = s_q.rfsh_en;
    end else begin
      s_d.rfsh_cnt = s_q.rfsh_cnt + 16'h0001;
    end
    if (rfsh_active) begin
      s_d.rfsh_width = s_q.rfsh_width - 8'h01;
    end
    if (!s_q.rfsh_en) begin
      s_d.rfsh_due = 1'b0;
      s_d.rfsh_width = 8'h00;
    end

    case (s_q.st)
      SPROM_IDLE: begin
        s_d.busy = 1'b0;
        if (s_q.rfsh_due && !rfsh_active) begin
          // short fixed low pulse suited to pseudo static self timing
          // a due raised in this same cycle wins over the clear
          s_d.rfsh_due = rfsh_wrap && s_q.rfsh_en;
          s_d.rfsh_width = 8'(SPROM_RFSH_PULSE_CYC);
        end else if (suspend_req_i && !rfsh_active) begin
          if (s_q.standby_mode && s_q.rfsh_en) begin
            s_d.st = SPROM_SUSP_PULSE;
            s_d.tmr = 16'(SUSP_PULSE_CYC);
          end else begin
            s_d.st = SPROM_SUSPEND;
          end
        end else if (mem_req_i && !rfsh_active && !s_q.rfsh_due && !s_q.ack) begin
          // the request still stands while ack shows; taking it again would repeat it
          s_d.st = SPROM_ACCESS;
          s_d.busy = 1'b1;
          s_d.cur_bank = (mem_bank_i < 2'(SPROM_NBANK)) ? mem_bank_i : 2'h0;
          s_d.req = mem_cmd_i;
          s_d.hi_phase = 1'b0;
          s_d.tmr = 16'h0000;
          s_d.rdata = 16'h0000;
        end
      end
      SPROM_ACCESS: begin
        // xt cycles stretch longer than sram cycles
        if (s_q.tmr < 16'({cb.wait_cnt}) + (xt_cycle ? 16'(SPROM_XT_EXTRA) : 16'h0000)) begin
          s_d.tmr = s_q.tmr + 16'h0001;
        end else if (xt_cycle && cb.wide && !s_q.hi_phase) begin
          // 16-bit rom transfer as two byte cycles, low byte first
          s_d.rdata[7:0] = rom_data_i;
          s_d.hi_phase = 1'b1;
          s_d.tmr = 16'h0000;
        end else begin
          if (xt_cycle) begin
            if (s_q.hi_phase) begin
              s_d.rdata[15:8] = rom_data_i;
            end else begin
              s_d.rdata[7:0] = rom_data_i;
            end
          end else if (cb.wide) begin
            s_d.rdata = ram_data_i;
          end else begin
            s_d.rdata = {8'h00, s_q.req.addr[0] ? ram_data_i[15:8] : ram_data_i[7:0]};
          end
          s_d.st = SPROM_DONE;
        end
        if (!acc_ok) begin
          s_d.st = SPROM_DONE;
        end
      end
      SPROM_DONE: begin
        s_d.ack = 1'b1;
        s_d.busy = 1'b0;
        s_d.st = SPROM_IDLE;
      end
      SPROM_SUSP_PULSE: begin
        // one long pulse drops the psram into self refresh
        s_d.rfsh_width = 8'h00;
        if (!s_q.rfsh_en || s_q.tmr == 16'h0000) begin
          s_d.st = SPROM_SUSPEND;
        end else begin
          s_d.tmr = s_q.tmr - 16'h0001;
        end
      end
      SPROM_SUSPEND: begin
        // no memory cycles here; leaving restarts periodic refresh at once
        s_d.rfsh_width = 8'h00;
        if (!suspend_req_i) begin
          s_d.st = SPROM_IDLE;
          s_d.rfsh_due = s_q.rfsh_en;
        end
      end
      default: s_d.st = SPROM_IDLE;
    endcase

    s_d.susp = (s_d.st == SPROM_SUSPEND);
    // pins, registered
    s_d.sram.bank_sel = 3'h0;
    for (int i = 0; i < SPROM_NBANK; i++) begin
      // bank n is driven by select n; polarity per bank
      s_d.sram.bank_sel[i] = s_d.bank[i].pol_high
        ^ !(s_d.st == SPROM_ACCESS && s_d.cur_bank == 2'(i)
            && s_d.bank[i].cyc == SPROM_CYC_SRAM);
    end
    // word banks shift by one, byte banks map straight through
    s_d.sram.sram_addr = s_d.bank[s_d.cur_bank].wide ? s_d.req.addr[19:1]
                                                      : s_d.req.addr[18:0];
    s_d.sram.oe_n = 2'h3;
    s_d.sram.we_n = 2'h3;
    s_d.sram.data_oe = 1'b0;
    s_d.sram.data_out = s_d.req.wdata;
    if (s_d.st == SPROM_ACCESS && s_d.bank[s_d.cur_bank].cyc == SPROM_CYC_SRAM) begin
      if (s_d.req.write) begin
        s_d.sram.we_n = ~s_d.req.lanes;
        s_d.sram.data_oe = 1'b1;
      end else begin
        s_d.sram.oe_n = ~s_d.req.lanes;
      end
    end
    s_d.sram.refresh_n = !(s_d.rfsh_en && ((s_d.rfsh_width != 8'h00)
                           || s_d.st == SPROM_SUSP_PULSE));
    // xt bus rom cycle
    s_d.rom.rom_addr = {s_d.req.addr[19:1], s_d.req.addr[0] | s_d.hi_phase};
    s_d.rom.boot_rom_select_n = !(s_d.bank[s_d.cur_bank].rom_sel
                                  && s_d.st != SPROM_SUSPEND
                                  && s_d.st != SPROM_SUSP_PULSE);
    s_d.rom.mem_read_strobe_n = !(s_d.st == SPROM_ACCESS && !s_d.req.write
                                  && s_d.bank[s_d.cur_bank].cyc == SPROM_CYC_XT);
    s_d.rom.mem_write_strobe_n = !(s_d.st == SPROM_ACCESS && s_d.req.write
                                   && s_d.bank[s_d.cur_bank].cyc == SPROM_CYC_XT);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.bank[0] <= {SPROM_WAIT_RST, SPROM_BANK0_RST[4:0]};
      s_q.bank[1] <= {SPROM_WAIT_RST, SPROM_BANKN_RST[4:0]};
      s_q.bank[2] <= {SPROM_WAIT_RST, SPROM_BANKN_RST[4:0]};
      s_q.st <= SPROM_IDLE;
      s_q.waitreq <= 1'b1;
      s_q.sram.bank_sel <= 3'h7;
      s_q.sram.oe_n <= 2'h3;
      s_q.sram.we_n <= 2'h3;
      s_q.sram.refresh_n <= 1'b1;
      s_q.rom.boot_rom_select_n <= 1'b0;
      s_q.rom.mem_read_strobe_n <= 1'b1;
      s_q.rom.mem_write_strobe_n <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flip-flops
  assign avs_readdata_o = s_q.rd;
  assign avs_waitrequest_o = s_q.waitreq;
  assign mem_ack_o = s_q.ack;
  assign mem_rdata_o = s_q.rdata;
  assign suspended_o = s_q.susp;
  assign sram_o = s_q.sram;
  assign rom_o = s_q.rom;

endmodule // sprom_ctrl

// ---- test/sprom_ctrl_checker.sv ----
// concurrent checks on the static memory and boot rom controller ports
`timescale 1ns/100ps
module sprom_ctrl_checker
  import sprom_pkg::*;
#(
  parameter int SUSP_PULSE_CYC = 10
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic avs_waitrequest_o,
  // status and pins
  input wire logic mem_ack_o,
  input wire logic suspended_o,
  input wire sprom_sram_pins_type sram_o,
  input wire sprom_rom_pins_type rom_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic en_q, st_q;
  logic [2:0] pol_q;
  logic [15:0] lo_q, run_q;
  ////////////////////////////////////////////////////////////////
  // shadow of the config bits; only a completed write counts
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q <= 1'b0;
      st_q <= 1'b0;
      pol_q <= 3'h0;
    end else if (avs_write_i && !avs_waitrequest_o) begin
      if (avs_address_i == SPROM_REG_REFRESH) en_q <= avs_writedata_i[0];
      if (avs_address_i == SPROM_REG_STANDBY) st_q <= avs_writedata_i[0];
      if (avs_address_i < 4'h3) pol_q[avs_address_i[1:0]] <= avs_writedata_i[4];
    end
  end
  // length of the current and of the last refresh low run
  always_ff @(posedge clk_i) begin
    lo_q <= sram_o.refresh_n ? 16'h0 : lo_q + 16'h1;
    if (sram_o.refresh_n && lo_q != 16'h0) run_q <= lo_q;
  end
  ////////////////////////////////////////////////////////////////
  property p_boot; $fell(rst_i) |-> !rom_o.boot_rom_select_n; endproperty
  a_boot: assert property (@(posedge clk_i) p_boot) else $error("boot rom select idle");
  property p_rf_off; !en_q |-> sram_o.refresh_n; endproperty
  a_rf_off: assert property (p_rf_off) else $error("refresh while disabled");
  // a pulse cut short by disabling refresh may end early
  property p_rf_shape; $fell(sram_o.refresh_n) |-> (!sram_o.refresh_n || !en_q)[*4];
  endproperty
  a_rf_shape: assert property (p_rf_shape) else $error("refresh pulse short");
  property p_susp; $rose(suspended_o) && st_q && en_q |->
    (lo_q >= SUSP_PULSE_CYC || run_q >= SUSP_PULSE_CYC); endproperty
  a_susp: assert property (p_susp) else $error("standby pulse short");
  property p_quiet; suspended_o |-> sram_o.oe_n == 2'b11 && sram_o.we_n == 2'b11; endproperty
  a_quiet: assert property (p_quiet) else $error("ram access in suspend");
  property p_one_bank; $onehot0(~(sram_o.bank_sel ^ pol_q)); endproperty
  a_one_bank: assert property (p_one_bank) else $error("two banks selected");
  property p_strobes; !rom_o.mem_read_strobe_n |-> rom_o.mem_write_strobe_n; endproperty
  a_strobes: assert property (p_strobes) else $error("both rom strobes low");
  property p_wait; (avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2] !avs_waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("register access not answered");
  property p_ack; mem_ack_o |=> !mem_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack longer than a cycle");
  c_susp: cover property ($rose(suspended_o));
  c_rom: cover property (!rom_o.mem_read_strobe_n);
  c_ram: cover property (sram_o.we_n != 2'b11);
endmodule // sprom_ctrl_checker
bind sprom_ctrl sprom_ctrl_checker #(.SUSP_PULSE_CYC(SUSP_PULSE_CYC)) u_chk (.clk_i(clk_i),
  .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_waitrequest_o(avs_waitrequest_o), .mem_ack_o(mem_ack_o), .suspended_o(suspended_o),
  .sram_o(sram_o), .rom_o(rom_o));

// ---- test/sprom_mem_model.sv ----
// behavioural static ram and byte wide rom behind the controller pins
`timescale 1ns/100ps
module sprom_mem_model
  import sprom_pkg::*;
(
  // clock
  input wire logic clk_i,
  // pins from the controller
  input wire sprom_sram_pins_type sram_i,
  input wire sprom_rom_pins_type rom_i,
  // data back to the controller
  output logic [15:0] ram_data_o,
  output logic [7:0] rom_data_o
);
  logic [15:0] mem [16];
  logic [15:0] ram_last = 16'h0;
  logic [7:0] rom_last = 8'h0;
  ////////////////////////////////////////////////////////////////
  // byte lanes written separately, one data line per bit
  always @(posedge clk_i) begin
    if (!sram_i.we_n[0]) mem[sram_i.sram_addr[3:0]][7:0] <= sram_i.data_out[7:0];
    if (!sram_i.we_n[1]) mem[sram_i.sram_addr[3:0]][15:8] <= sram_i.data_out[15:8];
    ram_last <= ram_data_o;
    rom_last <= rom_data_o;
  end
  // released lines show the inverse of the last value, never a held copy
  assign ram_data_o = sram_i.oe_n != 2'b11 ? mem[sram_i.sram_addr[3:0]] : ~ram_last;
  assign rom_data_o = !rom_i.boot_rom_select_n && !rom_i.mem_read_strobe_n ?
    rom_i.rom_addr[7:0] ^ 8'hA5 : ~rom_last;
endmodule // sprom_mem_model

// ---- test/sprom_ctrl_bench.sv ----
// self-checking bench for the static memory and boot rom controller
`timescale 1ns/100ps
module sprom_ctrl_bench;
  import sprom_pkg::*;
  localparam int SUSP = 10;
  logic clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, v;
  logic avs_waitrequest_o, mem_req_i = 1'b0, mem_ack_o, suspend_req_i = 1'b0, suspended_o;
  logic [1:0] mem_bank_i = 2'h0, cap_we;
  sprom_req_type mem_cmd_i = '0;
  logic [15:0] mem_rdata_o, ram_data_i, lo = 16'h0, last_len = 16'h0;
  logic [7:0] rom_data_i;
  logic [18:0] cap_a;
  logic [19:0] cap_r;
  logic [2:0] cap_bs;
  sprom_sram_pins_type sram_o;
  sprom_rom_pins_type rom_o;
  int n_mismatch = 0, n_checks = 0, n_rf = 0, n0;
  sprom_ctrl #(.RFSH_PERIOD(50), .SUSP_PULSE_CYC(SUSP)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mem_req_i(mem_req_i), .mem_bank_i(mem_bank_i),
    .mem_cmd_i(mem_cmd_i), .mem_ack_o(mem_ack_o), .mem_rdata_o(mem_rdata_o),
    .suspend_req_i(suspend_req_i), .suspended_o(suspended_o), .ram_data_i(ram_data_i),
    .sram_o(sram_o), .rom_data_i(rom_data_i), .rom_o(rom_o));
  sprom_mem_model u_mem (.clk_i(clk_i), .sram_i(sram_o), .rom_i(rom_o),
    .ram_data_o(ram_data_i), .rom_data_o(rom_data_i));
  ////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // pin capture and refresh pulse measurement, sampled mid cycle
  always @(negedge clk_i) begin
    if (sram_o.oe_n != 2'b11 || sram_o.we_n != 2'b11) begin
      cap_a <= sram_o.sram_addr;
      cap_bs <= sram_o.bank_sel;
      cap_we <= sram_o.we_n;
    end
    if (!rom_o.mem_read_strobe_n || !rom_o.mem_write_strobe_n) cap_r <= rom_o.rom_addr;
    if (!sram_o.refresh_n && lo == 16'h0) n_rf <= n_rf + 1;
    if (!sram_o.refresh_n) lo <= lo + 16'h1;
    else if (lo != 16'h0) begin
      last_len <= lo;
      lo <= 16'h0;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // avalon access: held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    v = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // memory request held until the ack pulse
  task automatic acc(input logic [1:0] b, input logic [19:0] a, input logic [15:0] d,
                     input logic w);
    @(posedge clk_i);
    mem_req_i <= 1'b1;
    mem_bank_i <= b;
    mem_cmd_i <= '{addr: a, wdata: d, lanes: 2'b11, write: w};
    do @(posedge clk_i); while (mem_ack_o !== 1'b1);
    mem_req_i <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    final_report();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(rom_o.boot_rom_select_n, 0);
    bus(1, 4'h5, 32'h7);
    bus(1, 4'hF, 32'h1);
    for (int i = 0; i < 7; i++) begin
      bus(0, i == 6 ? 4'hF : 4'(i), 0);
      chk(v, i == 0 ? 32'h30A : (i < 3 ? 32'h301 : 32'h0));
    end
    $display("test done: registers");
    acc(2'h0, 20'h12345, 0, 0);
    chk({cap_r, mem_rdata_o[7:0]}, {20'h12345, 8'hE0});
    bus(1, SPROM_REG_BANK0, 32'h30E);
    acc(2'h0, 20'h12344, 0, 0);
    chk(mem_rdata_o, 16'hE0E1);
    acc(2'h0, 20'h0ABCC, 16'h5A5A, 1);
    chk(cap_r, 20'h0ABCD);
    $display("test done: rom");
    bus(1, SPROM_REG_BANK1, 32'h315);
    @(negedge clk_i);
    chk(sram_o.bank_sel, 3'b101);
    acc(2'h1, 20'hABCDE, 16'h1234, 1);
    acc(2'h1, 20'hABCDE, 0, 0);
    chk({cap_a, cap_bs, mem_rdata_o}, {19'h55E6F, 3'b111, 16'h1234});
    acc(2'h2, 20'h54321, 16'hC3C3, 1);
    chk({cap_a, cap_bs, cap_we}, {19'h54321, 3'b001, 2'b00});
    $display("test done: sram");
    bus(1, SPROM_REG_STANDBY, 32'h1);
    n0 = n_rf;
    suspend_req_i <= 1'b1;
    do @(negedge clk_i); while (suspended_o !== 1'b1);
    bus(0, SPROM_REG_STATUS, 0);
    chk({31'(n_rf - n0), v[2]}, {31'h0, 1'b1});
    suspend_req_i <= 1'b0;
    bus(1, SPROM_REG_REFRESH, 32'h1);
    n0 = n_rf;
    repeat (120) @(negedge clk_i);
    chk({n_rf > n0 + 1, last_len}, {1'b1, 16'h4});
    @(posedge clk_i);
    suspend_req_i <= 1'b1;
    do @(negedge clk_i); while (suspended_o !== 1'b1);
    repeat (2) @(negedge clk_i);
    chk(last_len >= SUSP, 1);
    n0 = n_rf;
    @(posedge clk_i);
    suspend_req_i <= 1'b0;
    repeat (20) @(negedge clk_i);
    chk({n_rf > n0, suspended_o}, 2'b10);
    $display("test done: refresh");
    final_report();
  end
endmodule // sprom_ctrl_bench
